// ===== hdl/spindle_status_top.sv
// Functional notes
// - Ready flag on while drive reports ready.
// - Ready flag off while a drive alarm is present.
// - Ready flag off while the ready command to the drive is off.
// - Ready flag off when machine-ready input is off, unless disabled.
// - Servo flag on when ready, servo command delivered and drive servo state.
// - Servo flag clears once the servo command is withdrawn.
// - While servo flag set, run starts and orientation command are ignored.
// - Forward flag follows forward motor rotation, also in orient or tapping.
// - Reverse flag follows reverse motor rotation, also in orient or tapping.
// - Index flag sets when encoder index passes in C-axis control.
// - Index flag clears when servo or ready flag drops, else holds.
// - In-position on during tapping with servo when error in range.
// - In-position on whenever the link is attached and tapping is not commanded.
// - In-position off when error exceeds range during tapping with servo.
// - Torque-limit flag on when either torque-limit command is on.
// - Torque-limit flag off only when both commands are off or the link is detached.
// - Flags produced only while the drive is attached over serial link.
// - Each spindle's ready flag has its own status location.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "spindle_status_regs.svh"
module spindle_status_top #(
    parameter int NUM_SPINDLES = 3
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [`REG_ADR_W-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input spindle_status_pkg::drive_status_t DRIVE_STAT_I [NUM_SPINDLES],
    output spindle_status_pkg::drive_cmd_t DRIVE_CMD_O [NUM_SPINDLES],
    output spindle_status_pkg::spindle_flags_t FLAGS_O [NUM_SPINDLES]
);
    generate
        if (NUM_SPINDLES < 1 || NUM_SPINDLES > `MAX_SPINDLES) begin : g_bad_count
            $error("NUM_SPINDLES must be 1 to 4");
        end
    endgenerate

    spindle_status_pkg::drive_status_t sync1_reg [NUM_SPINDLES];
    spindle_status_pkg::drive_status_t sync2_reg [NUM_SPINDLES];
    logic [NUM_SPINDLES-1:0] index_prev_reg;
    logic [`CTRL_W-1:0] ctrl_reg [NUM_SPINDLES];
    spindle_status_pkg::spindle_flags_t flags_w [NUM_SPINDLES];
    logic ack_reg;
    logic [31:0] dat_reg;
    logic req;
    logic [3:0] region;
    logic [1:0] index;
    logic hit;
    localparam logic [`CTRL_W-1:0] CTRL_MASK = `CTRL_USED_MASK;

    // Drive status arrives from outside the clock domain
    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < NUM_SPINDLES; i++) begin
            if (RST_I) begin
                sync1_reg[i] <= '0;
                sync2_reg[i] <= '0;
                index_prev_reg[i] <= 1'b0;
            end else begin
                sync1_reg[i] <= DRIVE_STAT_I[i];
                sync2_reg[i] <= sync1_reg[i];
                index_prev_reg[i] <= sync2_reg[i].index_pulse;
            end
        end
    end

    assign req = CYC_I && STB_I && !ack_reg;
    assign region = ADR_I[7:4];
    assign index = ADR_I[3:2];
    assign hit = (ADR_I[1:0] == 2'h0) && (32'(index) < NUM_SPINDLES);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Control registers: byte lanes 0 and 1 hold the fields
    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < NUM_SPINDLES; i++) begin
            if (RST_I) begin
                ctrl_reg[i] <= `CTRL_RESET;
            end else if (req && WE_I && hit && region == `REGION_CTRL
                         && 32'(index) == i) begin
                if (SEL_I[0]) begin
                    ctrl_reg[i][7:0] <= DAT_I[7:0] & CTRL_MASK[7:0];
                end
                if (SEL_I[1]) begin
                    ctrl_reg[i][15:8] <= DAT_I[15:8] & CTRL_MASK[15:8];
                end
            end
        end
    end

    // Reads of unmapped or misaligned addresses answer zero
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dat_reg <= 32'h00000000;
        end else if (req) begin
            dat_reg <= 32'h00000000;
            if (hit && !WE_I) begin
                case (region)
                    `REGION_CTRL: dat_reg <= 32'(ctrl_reg[index]);
                    `REGION_STATUS: dat_reg <= 32'(
                        spindle_status_pkg::flags_to_byte(flags_w[index]));
                    `REGION_DRIVE: dat_reg <= 32'(sync2_reg[index]);
                    default: dat_reg <= 32'h00000000;
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SPINDLES; g++) begin : g_spindle
            spindle_flag_unit u_unit (
                .clk_i(CLK_I),
                .rst_i(RST_I),
                .stat_i(sync2_reg[g]),
                .index_edge_i(sync2_reg[g].index_pulse && !index_prev_reg[g]),
                .cmd_i(spindle_status_pkg::ctrl_to_cmd(ctrl_reg[g])),
                .flags_o(flags_w[g]),
                .drive_cmd_o(DRIVE_CMD_O[g])
            );
            assign FLAGS_O[g] = flags_w[g];
        end
    endgenerate

    assign ACK_O = ack_reg;
    assign DAT_O = dat_reg;
endmodule // spindle_status_top

// ===== hdl/spindle_status_regs.svh
`ifndef SPINDLE_STATUS_REGS_SVH
`define SPINDLE_STATUS_REGS_SVH

// Register map, byte addresses on the Wishbone bus
`define REG_ADR_W 8
`define CTRL_BASE 8'h00
`define STATUS_BASE 8'h10
`define DRIVE_BASE 8'h20
`define REG_STRIDE 8'h04
`define REGION_CTRL 4'h0
`define REGION_STATUS 4'h1
`define REGION_DRIVE 4'h2
`define MAX_SPINDLES 4

// Control register fields, one register per spindle
`define CTRL_W 16
`define CTRL_RESET 16'h0000
`define CTRL_LINK_BIT 0
`define CTRL_READY_CMD_BIT 1
`define CTRL_MR_DISABLE_BIT 2
`define CTRL_SERVO_CMD_BIT 3
`define CTRL_TAP_CMD_BIT 4
`define CTRL_TQ_A_BIT 5
`define CTRL_TQ_B_BIT 6
`define CTRL_FWD_BIT 8
`define CTRL_REV_BIT 9
`define CTRL_ORIENT_BIT 10
`define CTRL_USED_MASK 16'h077F

// Status register fields, bit n mirrors input bit address offset 8+n
`define STAT_READY_BIT 0
`define STAT_SERVO_BIT 1
`define STAT_FWD_BIT 3
`define STAT_REV_BIT 4
`define STAT_INDEX_BIT 5
`define STAT_INPOS_BIT 6
`define STAT_TORQUE_BIT 7

`endif

// ===== hdl/spindle_status_pkg.sv
package spindle_status_pkg;
`include "spindle_status_regs.svh"

    typedef struct packed {
        logic ready_rpt;
        logic alarm;
        logic machine_ready;
        logic servo_state;
        logic motor_fwd;
        logic motor_rev;
        logic index_pulse;
        logic c_axis_active;
        logic droop_in_range;
    } drive_status_t;

    typedef struct packed {
        logic link_attached;
        logic ready_cmd;
        logic mr_disable;
        logic servo_cmd;
        logic tap_cmd;
        logic torque_limit_cmd_a;
        logic torque_limit_cmd_b;
        logic forward_run_start;
        logic reverse_run_start;
        logic orientation_command;
    } spindle_cmd_t;

    typedef struct packed {
        logic ready_cmd;
        logic servo_cmd;
        logic forward_run_start;
        logic reverse_run_start;
        logic orientation_command;
        logic torque_limit_cmd_a;
        logic torque_limit_cmd_b;
    } drive_cmd_t;

    typedef struct packed {
        logic drive_ready_flag;
        logic servo_on_flag;
        logic forward_rotation_flag;
        logic reverse_rotation_flag;
        logic index_passed_flag;
        logic loop_in_position_flag;
        logic torque_limit_active_flag;
    } spindle_flags_t;

    function automatic spindle_cmd_t ctrl_to_cmd(input logic [`CTRL_W-1:0] c);
        spindle_cmd_t r;
        r.link_attached = c[`CTRL_LINK_BIT];
        r.ready_cmd = c[`CTRL_READY_CMD_BIT];
        r.mr_disable = c[`CTRL_MR_DISABLE_BIT];
        r.servo_cmd = c[`CTRL_SERVO_CMD_BIT];
        r.tap_cmd = c[`CTRL_TAP_CMD_BIT];
        r.torque_limit_cmd_a = c[`CTRL_TQ_A_BIT];
        r.torque_limit_cmd_b = c[`CTRL_TQ_B_BIT];
        r.forward_run_start = c[`CTRL_FWD_BIT];
        r.reverse_run_start = c[`CTRL_REV_BIT];
        r.orientation_command = c[`CTRL_ORIENT_BIT];
        return r;
    endfunction

    function automatic logic [7:0] flags_to_byte(input spindle_flags_t f);
        logic [7:0] b;
        b = 8'h00;
        b[`STAT_READY_BIT] = f.drive_ready_flag;
        b[`STAT_SERVO_BIT] = f.servo_on_flag;
        b[`STAT_FWD_BIT] = f.forward_rotation_flag;
        b[`STAT_REV_BIT] = f.reverse_rotation_flag;
        b[`STAT_INDEX_BIT] = f.index_passed_flag;
        b[`STAT_INPOS_BIT] = f.loop_in_position_flag;
        b[`STAT_TORQUE_BIT] = f.torque_limit_active_flag;
        return b;
    endfunction
endpackage

// ===== hdl/spindle_flag_unit.sv
`timescale 1ns/1ps
module spindle_flag_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input spindle_status_pkg::drive_status_t stat_i,
    input wire logic index_edge_i,
    input spindle_status_pkg::spindle_cmd_t cmd_i,
    output spindle_status_pkg::spindle_flags_t flags_o,
    output spindle_status_pkg::drive_cmd_t drive_cmd_o
);
    spindle_status_pkg::spindle_flags_t flags_reg;
    spindle_status_pkg::drive_cmd_t drive_cmd_reg;
    logic index_passed_reg;
    logic in_position_reg;
    logic ready_next;
    logic servo_next;
    logic link;

    assign link = cmd_i.link_attached;
    assign ready_next = link && stat_i.ready_rpt
        && !stat_i.alarm
        && cmd_i.ready_cmd
        && (stat_i.machine_ready || cmd_i.mr_disable);
    // Servo flag needs the command already delivered to the drive
    assign servo_next = ready_next && drive_cmd_reg.servo_cmd && cmd_i.servo_cmd
        && stat_i.servo_state;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_cmd_reg <= '0;
        end else begin
            drive_cmd_reg.ready_cmd <= cmd_i.ready_cmd;
            drive_cmd_reg.servo_cmd <= cmd_i.servo_cmd;
            drive_cmd_reg.torque_limit_cmd_a <= cmd_i.torque_limit_cmd_a;
            drive_cmd_reg.torque_limit_cmd_b <= cmd_i.torque_limit_cmd_b;
            drive_cmd_reg.forward_run_start <= cmd_i.forward_run_start
                && !flags_reg.servo_on_flag;
            drive_cmd_reg.reverse_run_start <= cmd_i.reverse_run_start
                && !flags_reg.servo_on_flag;
            drive_cmd_reg.orientation_command <= cmd_i.orientation_command
                && !flags_reg.servo_on_flag;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg.drive_ready_flag <= ready_next;
            flags_reg.servo_on_flag <= servo_next;
            flags_reg.forward_rotation_flag <= link && stat_i.motor_fwd;
            flags_reg.reverse_rotation_flag <= link && stat_i.motor_rev;
            flags_reg.torque_limit_active_flag <= link
                && (cmd_i.torque_limit_cmd_a || cmd_i.torque_limit_cmd_b);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            index_passed_reg <= 1'b0;
        end else if (!(ready_next && servo_next)) begin
            index_passed_reg <= 1'b0;
        end else if (index_edge_i && stat_i.c_axis_active) begin
            index_passed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_position_reg <= 1'b0;
        end else if (!link) begin
            in_position_reg <= 1'b0;
        end else if (!cmd_i.tap_cmd) begin
            in_position_reg <= 1'b1;
        end else if (servo_next) begin
            in_position_reg <= stat_i.droop_in_range;
        end
    end

    // Index and in-position flags live in their own registers
    always_comb begin
        flags_o = flags_reg;
        flags_o.index_passed_flag = index_passed_reg;
        flags_o.loop_in_position_flag = in_position_reg;
    end
    assign drive_cmd_o = drive_cmd_reg;
endmodule // spindle_flag_unit

// ===== testbench/spindle_drive_model.sv
`timescale 1ns/1ps
module spindle_drive_model #(
    parameter int LAG = 0
) (
    input wire logic clk_i,
    input spindle_status_pkg::drive_cmd_t cmd_i,
    input spindle_status_pkg::drive_status_t env_i,
    output spindle_status_pkg::drive_status_t stat_o
);
    logic [7:0] servo_pipe_reg = 8'h00;
    // Drive enters servo state only some cycles after the command arrives
    always_ff @(posedge clk_i) begin
        servo_pipe_reg <= {servo_pipe_reg[6:0], cmd_i.servo_cmd};
    end
    always_comb begin
        stat_o = env_i;
        stat_o.servo_state = env_i.servo_state & servo_pipe_reg[LAG];
    end
endmodule // spindle_drive_model

// ===== testbench/spindle_status_top_asserts.sv
`timescale 1ns/1ps
module spindle_status_asserts #(
    parameter int NUM_SPINDLES = 3
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input spindle_status_pkg::drive_status_t DRIVE_STAT_I [NUM_SPINDLES],
    input spindle_status_pkg::drive_cmd_t DRIVE_CMD_O [NUM_SPINDLES],
    input spindle_status_pkg::spindle_flags_t FLAGS_O [NUM_SPINDLES]
);
    spindle_status_pkg::spindle_flags_t f;
    spindle_status_pkg::drive_cmd_t c;
    spindle_status_pkg::drive_status_t s;
    assign f = FLAGS_O[0];
    assign c = DRIVE_CMD_O[0];
    assign s = DRIVE_STAT_I[0];
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_ready_report: assert property (
        f.drive_ready_flag |-> $past(s.ready_rpt, 3) && !$past(s.alarm, 3))
        else $error("ready flag without drive report");
    a_ready_command: assert property (f.drive_ready_flag |-> c.ready_cmd)
        else $error("ready flag without ready command");
    a_servo_withdraw: assert property (
        !c.servo_cmd |-> !f.servo_on_flag ##1 !f.servo_on_flag)
        else $error("servo flag without command");
    a_runs_blocked: assert property (
        f.servo_on_flag |=> !(c.forward_run_start || c.reverse_run_start
            || c.orientation_command))
        else $error("run start passed under servo");
    a_fwd_motion: assert property (
        f.forward_rotation_flag |-> $past(s.motor_fwd, 3))
        else $error("forward flag without motion");
    a_torque_cmds: assert property (
        f.torque_limit_active_flag |-> c.torque_limit_cmd_a || c.torque_limit_cmd_b)
        else $error("torque flag without command");
    a_index_hold: assert property (
        f.index_passed_flag |-> f.servo_on_flag && f.drive_ready_flag)
        else $error("index flag kept after drop");
    a_index_set: assert property (
        $rose(f.index_passed_flag) |-> $past(s.c_axis_active, 3)
            && $past(s.index_pulse, 3) && !$past(s.index_pulse, 4))
        else $error("index flag without pulse");
endmodule // spindle_status_asserts

bind spindle_status_top spindle_status_asserts #(.NUM_SPINDLES(NUM_SPINDLES)) u_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .DRIVE_STAT_I(DRIVE_STAT_I), .DRIVE_CMD_O(DRIVE_CMD_O), .FLAGS_O(FLAGS_O));

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0, dr, q, e, m;
    logic ack;
    int err_total = 0, checked = 0, seed = 32'hF1A46879;
    spindle_status_pkg::drive_status_t env [3] = '{default: '0};
    spindle_status_pkg::drive_status_t stat [3];
    spindle_status_pkg::drive_cmd_t dcmd [3];
    spindle_status_pkg::spindle_flags_t flg [3];
    logic [15:0] ctl [3];
    always #20 clk = ~clk;
    spindle_status_top #(.NUM_SPINDLES(3)) dut (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dw), .DAT_O(dr),
        .ACK_O(ack), .DRIVE_STAT_I(stat), .DRIVE_CMD_O(dcmd), .FLAGS_O(flg));
    for (genvar n = 0; n < 3; n++) begin : g_drv
        spindle_drive_model #(.LAG(n * 3)) u_drv (.clk_i(clk), .cmd_i(dcmd[n]),
            .env_i(env[n]), .stat_o(stat[n]));
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] g, x, mk);
        checked++;
        if (((g ^ x) & mk) !== 32'h0) begin
            err_total++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, g, x);
        end
    endtask
    function automatic logic [31:0] exp_st(input logic [15:0] c,
        input spindle_status_pkg::drive_status_t s, output logic [31:0] mk);
        logic rd, sv;
        rd = c[0] & s.ready_rpt & ~s.alarm & c[1] & (s.machine_ready | c[2]);
        sv = rd & c[3] & s.servo_state;
        mk = {17'h0, 7'h7F, 1'b1, ~(c[0] & c[4] & ~sv), ~sv, 5'h1F};
        return {17'h0, c[1], c[3], c[8] & ~sv, c[9] & ~sv, c[10] & ~sv, c[5], c[6],
            c[0] & (c[5] | c[6]), c[0] & (~c[4] | s.droop_in_range), 1'b0,
            c[0] & s.motor_rev, c[0] & s.motor_fwd, 1'b0, sv, rd};
    endfunction
    task automatic rand_round();
        logic [31:0] x;
        for (int n = 0; n < 3; n++) begin
            x = $random(seed);
            ctl[n] = (x[15:0] | {14'h0, {2{x[16]}}}) & 16'h077F;
            x = $random(seed);
            env[n] <= x[12] ? {4'hB, x[4:0]} : x[8:0];
            wb(1'b1, 8'(4 * n), {16'h0, ctl[n]});
        end
        repeat (12) @(posedge clk);
        for (int n = 0; n < 3; n++) begin
            wb(1'b0, 8'(8'h10 + 4 * n), 32'h0);
            e = exp_st(ctl[n], env[n], m);
            cmp({17'h0, dcmd[n], q[7:0]}, e, m);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        env[0] <= 9'h162;
        wb(1'b1, 8'h00, 32'h0000000B);
        repeat (8) @(posedge clk);
        env[0] <= 9'h166;
        repeat (5) @(posedge clk);
        env[0] <= 9'h162;
        repeat (5) @(posedge clk);
        wb(1'b0, 8'h10, 32'h0);
        cmp(q, 32'h63, 32'hFFFFFFFF);
        wb(1'b0, 8'h20, 32'h0);
        cmp(q, 32'h162, 32'hFFFFFFFF);
        env[0] <= 9'h1E2;
        repeat (5) @(posedge clk);
        wb(1'b0, 8'h10, 32'h0);
        cmp(q, 32'h40, 32'hFFFFFFFF);
        wb(1'b1, 8'h00, 32'hFFFFFFFF);
        wb(1'b0, 8'h00, 32'h0);
        cmp(q, 32'h077F, 32'hFFFFFFFF);
        wb(1'b0, 8'h3C, 32'h0);
        cmp(q, 32'h0, 32'hFFFFFFFF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp({25'h0, flg[0]}, 32'h0, 32'hFFFFFFFF);
        wb(1'b0, 8'h00, 32'h0);
        cmp(q, 32'h0, 32'hFFFFFFFF);
        repeat (40) rand_round();
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED %0t: timeout", $time);
        stop_test();
    end
endmodule // testbench
